// ### shared/scs_pkg.sv
// Package for the smart card contact sequencer: timing counts, modes, carriers.
// Assumes one 100 MHz system clock that stands for the crystal input clock.
package scs_pkg;

	// System clock period in ns
	localparam int unsigned CLK_PERIOD_NS = 10;

	// Card clock divider codes (select_a, select_b)
	localparam logic [1:0] DIV_SEL_8 = 2'h0;
	localparam logic [1:0] DIV_SEL_4 = 2'h1;
	localparam logic [1:0] DIV_SEL_1 = 2'h2;
	localparam logic [1:0] DIV_SEL_2 = 2'h3;

	// Least card clock phase and delay before a new ratio applies, in input periods
	localparam int unsigned CLK_MIN_PHASE  = 8;
	localparam int unsigned DIV_APPLY_DLY  = 8;

	// Sequencer unit: 64 internal-oscillator periods, counted in half units
	localparam int unsigned OSC_PER_UNIT   = 64;
	localparam int unsigned HALF_UNIT_OSC  = OSC_PER_UNIT / 2;

	// Activation points, in half units after t1
	localparam logic [3:0] ACT_VCC_HALF    = 4'h3;  // 1.5 T
	localparam logic [3:0] ACT_IO_HALF     = 4'h8;  // 4 T
	localparam logic [3:0] ACT_RST_HALF    = 4'he;  // 7 T

	// Deactivation points, in half units after t10
	localparam logic [3:0] DEA_CLK_HALF    = 4'h1;  // 0.5 T
	localparam logic [3:0] DEA_IO_HALF     = 4'h2;  // 1 T
	localparam logic [3:0] DEA_VCC_HALF    = 4'h3;  // 1.5 T
	localparam logic [3:0] DEA_OFF_HALF    = 4'ha;  // 5 T

	// Least gap between data-line enable and clock start
	localparam int unsigned CLK_START_NS   = 200;
	localparam int unsigned CLK_START_CYC  =
		(CLK_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Card insertion debounce, 8 ms
	localparam int unsigned DEBOUNCE_MS    = 8;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;

	// Sequencer states
	typedef enum logic [4:0] {
		SCS_INACTIVE = 5'b0_0001,
		SCS_START    = 5'b0_0010,
		SCS_ACTIVATE = 5'b0_0100,
		SCS_ACTIVE   = 5'b0_1000,
		SCS_DEACT    = 5'b1_0000
	} scs_state_t;

	// Card-side contact controls
	typedef struct packed {
		logic vcc_en;      // Card supply ramp enable
		logic pump_en;     // Pump output on
		logic io_en;       // Data lines released (else held low)
		logic rst_lvl;     // Card reset level
		logic clk_en;      // Card clock gate
	} scs_contact_t;

endpackage : scs_pkg

// ### hdl/scs_line_xcvr.sv
// One bidirectional line transceiver between host side and card side.
// Assumes both line inputs are already synchronised to clk_i.
module scs_line_xcvr #(
	parameter int unsigned EDGE_DLY = 2,
	parameter int unsigned PU_DLY   = 4
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Enable (card side released)
	input  wire logic enable_i,
	// Host side
	input  wire logic host_in_i,
	output logic      host_out_o,
	output logic      host_oe_o,
	// Card side
	input  wire logic card_in_i,
	output logic      card_out_o,
	output logic      card_oe_o
);

	typedef enum logic [4:0] {
		LX_IDLE  = 5'b0_0001,
		LX_HWAIT = 5'b0_0010,
		LX_HMAST = 5'b0_0100,
		LX_CWAIT = 5'b0_1000,
		LX_CMAST = 5'b1_0000
	} lx_state_t;

	lx_state_t  state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic       host_q, card_q;
	logic       pu_q, pu_d;

	// Next state: first falling edge wins mastership
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		pu_d    = 1'b0;
		if (cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
		end
		unique case (state_q)
			LX_IDLE: begin
				if (!enable_i) begin
					state_d = LX_IDLE;
				end else if (host_q && !host_in_i) begin
					state_d = LX_HWAIT; // R6
					cnt_d   = 4'(EDGE_DLY);
				end else if (card_q && !card_in_i) begin
					state_d = LX_CWAIT; // R6
					cnt_d   = 4'(EDGE_DLY);
				end
			end
			LX_HWAIT, LX_CWAIT: begin
				if (cnt_q == 4'h0) begin
					state_d = (state_q == LX_HWAIT) ? LX_HMAST : LX_CMAST;
				end
			end
			LX_HMAST: begin
				if (host_in_i) begin
					state_d = LX_IDLE; // R8
					pu_d    = 1'b1;
					cnt_d   = 4'(PU_DLY - 1); // Pulse stands while count runs down to zero
				end
			end
			LX_CMAST: begin
				if (card_in_i) begin
					state_d = LX_IDLE; // R8
					pu_d    = 1'b1;
					cnt_d   = 4'(PU_DLY - 1);
				end
			end
			default: state_d = LX_IDLE;
		endcase
		if (pu_q && cnt_q != 4'h0) begin
			pu_d = 1'b1;
		end
		if (!enable_i) begin
			state_d = LX_IDLE;
		end
	end

	// Direction of the last pull-up pulse
	logic pu_card_q, pu_card_d;
	always_comb begin
		pu_card_d = pu_card_q;
		if (state_q == LX_HMAST) begin
			pu_card_d = 1'b1;
		end else if (state_q == LX_CMAST) begin
			pu_card_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= LX_IDLE;
			cnt_q     <= 4'h0;
			host_q    <= 1'b1;
			card_q    <= 1'b1;
			pu_q      <= 1'b0;
			pu_card_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			host_q    <= host_in_i;
			card_q    <= card_in_i;
			pu_q      <= pu_d;
			pu_card_q <= pu_card_d;
		end
	end

	// Slave side copies the low, then gets an active high pulse
	always_comb begin
		host_out_o = 1'b0;
		host_oe_o  = 1'b0;
		card_out_o = 1'b0;
		card_oe_o  = 1'b0;
		if (!enable_i) begin
			card_oe_o = 1'b1; // Card contact held low while disabled
		end else if (state_q == LX_HMAST) begin
			card_oe_o = 1'b1; // R7
		end else if (state_q == LX_CMAST) begin
			host_oe_o = 1'b1; // R7
		end else if (pu_q) begin
			if (pu_card_q) begin
				card_out_o = 1'b1; // R8
				card_oe_o  = 1'b1;
			end else begin
				host_out_o = 1'b1; // R8
				host_oe_o  = 1'b1;
			end
		end
	end

endmodule // scs_line_xcvr

// ### hdl/scs_sequencer.sv
// Smart card contact sequencer: clock divider, activation and deactivation,
// presence debounce, fault handling and three line transceivers.
// Assumes clk_i is the crystal clock and osc_clock_input_i the internal oscillator.
// Contract
// R1: Divide selects give 8, 4, 2 or 1; the code gives 2 for the 1 select.
// R2: Host changes selects one at a time.
// R3: Card clock phases last eight input periods; the code gives 4, 2 or 1 input periods per phase.
// R4: Ratio switches glitch-free at phase boundaries.
// R5: New ratio applies eight periods after change.
// R6: First falling side becomes line master.
// R7: Slave side driven low after edge delay.
// R8: Slave driven high for pull-up pulse.
// R9: Reset enters inactive mode, contacts low.
// R10: Idle status shows card presence.
// R11: Session request low starts oscillator, doubler.
// R12: Unit is 64 oscillator periods; supply at 1.5T.
// R13: Data lines at 4T, reset at 7T.
// R14: Clock starts when reset request falls.
// R15: Card reset follows request after 7T.
// R16: Otherwise clock starts at 4T plus 200ns.
// R17: Host avoids activation with request stuck high.
// R18: Deactivation: reset, clock, lines at 0, 0.5T, 1T.
// R19: Supply falls 1.5T, pump off 5T, inactive.
// R20: Fault drives status low, emergency deactivation.
// R21: Outside session faults leave status unchanged.
// R22: Insertion debounced 8 ms; extraction deactivates.
module scs_sequencer #(
	parameter int unsigned DEBOUNCE_CYC = scs_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Internal oscillator, sampled as a pin
	input  wire logic                 osc_clock_input_i,
	// Host control pins
	input  wire logic                 clock_divide_select_a_i,
	input  wire logic                 clock_divide_select_b_i,
	input  wire logic                 session_request_n_i,
	input  wire logic                 card_reset_request_i,
	output logic                      status_n_o,
	// Card detect and faults
	input  wire logic                 card_detect_input_i,
	input  wire logic                 fault_i,
	// Card contacts
	output logic                      card_clock_o,
	output logic                      card_reset_o,
	output scs_pkg::scs_contact_t     contact_o,
	output logic                      osc_high_freq_o,
	// Host lines: data, aux a, aux b
	input  wire logic [2:0]           host_line_in_i,
	output logic [2:0]                host_line_out_o,
	output logic [2:0]                host_line_oe_o,
	// Card lines
	input  wire logic [2:0]           card_line_in_i,
	output logic [2:0]                card_line_out_o,
	output logic [2:0]                card_line_oe_o
);

	// Two-stage synchronisers for every pin input
	localparam int unsigned NSYNC = 11;
	logic [NSYNC-1:0] pin_raw, sync1_q, sync2_q;
	assign pin_raw = {host_line_in_i, card_line_in_i, osc_clock_input_i,
		clock_divide_select_a_i, clock_divide_select_b_i, session_request_n_i,
		card_reset_request_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	logic [2:0] host_s, card_s;
	logic       osc_s, sel_a_s, sel_b_s, req_n_s, rstreq_s, det_s, fault_s;
	assign host_s   = sync2_q[10:8];
	assign card_s   = sync2_q[7:5];
	assign osc_s    = sync2_q[4];
	assign sel_a_s  = sync2_q[3];
	assign sel_b_s  = sync2_q[2];
	assign req_n_s  = sync2_q[1];
	assign rstreq_s = sync2_q[0];

	// Presence and fault synchronisers, reset low (no card)
	logic [1:0] misc1_q, misc2_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc1_q <= 2'h0;
			misc2_q <= 2'h0;
		end else begin
			misc1_q <= {card_detect_input_i, fault_i};
			misc2_q <= misc1_q;
		end
	end
	assign det_s   = misc2_q[1];
	assign fault_s = misc2_q[0];

	// Card clock divider: switch ratio only at a phase end, after the delay
	logic [1:0] sel_now, sel_q, sel_d, pend_q, pend_d;
	logic [3:0] apply_q, apply_d;
	logic [2:0] ph_q, ph_d;
	logic       cclk_q, cclk_d;
	logic [2:0] ph_len;
	assign sel_now = {sel_a_s, sel_b_s};
	always_comb begin
		unique case (sel_q)
			scs_pkg::DIV_SEL_8: ph_len = 3'h3; // R1
			scs_pkg::DIV_SEL_4: ph_len = 3'h1; // R1
			scs_pkg::DIV_SEL_2: ph_len = 3'h0; // R1
			scs_pkg::DIV_SEL_1: ph_len = 3'h0; // R1
		endcase
	end
	always_comb begin
		pend_d  = pend_q;
		apply_d = apply_q;
		sel_d   = sel_q;
		ph_d    = ph_q;
		cclk_d  = cclk_q;
		if (sel_now != pend_q) begin
			pend_d  = sel_now;
			apply_d = 4'(scs_pkg::DIV_APPLY_DLY - 1); // R5
		end else if (apply_q != 4'h0) begin
			apply_d = apply_q - 4'h1;
		end
		if (sel_q == scs_pkg::DIV_SEL_1) begin
			cclk_d = ~cclk_q; // Select 1 divides by two: one phase per cycle
			ph_d   = 3'h0;
			if (cclk_q && apply_q == 4'h0 && pend_q != sel_q) begin
				sel_d = pend_q; // R4
			end
		end else if (ph_q >= ph_len) begin
			ph_d   = 3'h0;
			cclk_d = ~cclk_q;
			if (cclk_q && apply_q == 4'h0 && pend_q != sel_q) begin
				sel_d = pend_q; // R4
			end
		end else begin
			ph_d = ph_q + 3'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q   <= scs_pkg::DIV_SEL_8;
			pend_q  <= scs_pkg::DIV_SEL_8;
			apply_q <= 4'h0;
			ph_q    <= 3'h0;
			cclk_q  <= 1'b0;
		end else begin
			sel_q   <= sel_d;
			pend_q  <= pend_d;
			apply_q <= apply_d;
			ph_q    <= ph_d;
			cclk_q  <= cclk_d;
		end
	end

	// Card clock gate changes only while the divided clock is low
	logic gate_q, gate_d, want_clk;
	always_comb begin
		gate_d = gate_q;
		if (!cclk_q) begin
			gate_d = want_clk; // R3
		end
	end

	// Half-unit tick from the internal oscillator edges
	logic       osc_q;
	logic [5:0] osc_cnt_q, osc_cnt_d;
	logic       half_tick;
	always_comb begin
		osc_cnt_d = osc_cnt_q;
		half_tick = 1'b0;
		if (osc_s && !osc_q) begin
			if (osc_cnt_q == 6'(scs_pkg::HALF_UNIT_OSC - 1)) begin
				osc_cnt_d = 6'h0; // R12
				half_tick = 1'b1;
			end else begin
				osc_cnt_d = osc_cnt_q + 6'h1;
			end
		end
	end

	// Presence debounce: insertion waits, extraction acts at once
	logic [23:0] deb_q, deb_d;
	logic        present_q, present_d;
	always_comb begin
		deb_d     = deb_q;
		present_d = present_q;
		if (!det_s) begin
			present_d = 1'b0; // R22
			deb_d     = 24'h0;
		end else if (!present_q) begin
			if (deb_q == 24'(DEBOUNCE_CYC - 1)) begin
				present_d = 1'b1; // R22
			end else begin
				deb_d = deb_q + 24'h1;
			end
		end
	end

	// Sequencer state
	scs_pkg::scs_state_t  state_q, state_d;
	scs_pkg::scs_contact_t con_q, con_d;
	logic [3:0]  half_q, half_d;
	logic        hold_q, hold_d;      // Clock waits for reset request to fall
	logic        fault_q, fault_d;    // Session ended on a fault
	logic [4:0]  cs_cnt_q, cs_cnt_d;
	logic        cs_arm_q, cs_arm_d;
	always_comb begin
		state_d  = state_q;
		con_d    = con_q;
		half_d   = half_q;
		hold_d   = hold_q;
		fault_d  = fault_q;
		cs_cnt_d = cs_cnt_q;
		cs_arm_d = cs_arm_q;
		if (half_tick) begin
			half_d = half_q + 4'h1;
		end
		if (cs_arm_q && cs_cnt_q != 5'h0) begin
			cs_cnt_d = cs_cnt_q - 5'h1;
		end
		unique case (state_q)
			scs_pkg::SCS_INACTIVE: begin
				con_d = '0; // R9
				// A stored fault is only forgotten once the host has raised the request
				if (req_n_s) begin
					fault_d = 1'b0; // R20
				end
				if (!req_n_s && present_q && !fault_q) begin
					state_d = scs_pkg::SCS_START; // R11
					hold_d  = rstreq_s;           // R14
					half_d  = 4'h0;
				end
			end
			scs_pkg::SCS_START: begin
				con_d.pump_en = 1'b1; // R11
				if (half_tick) begin
					state_d = scs_pkg::SCS_ACTIVATE; // t1 reached
					half_d  = 4'h0;
				end
				// Abort before t1 too, so a fault never waits for the first tick
				if (req_n_s || fault_s || !present_q) begin
					state_d = scs_pkg::SCS_DEACT; // R20
					half_d  = 4'h0;
					fault_d = fault_s || !present_q;
				end
			end
			scs_pkg::SCS_ACTIVATE, scs_pkg::SCS_ACTIVE: begin
				if (half_q >= scs_pkg::ACT_VCC_HALF) begin
					con_d.vcc_en = 1'b1; // R12
				end
				if (half_q >= scs_pkg::ACT_IO_HALF && !con_q.io_en) begin
					con_d.io_en = 1'b1; // R13
					cs_arm_d    = 1'b1;
					cs_cnt_d    = 5'(scs_pkg::CLK_START_CYC);
				end
				if (state_q == scs_pkg::SCS_ACTIVATE && hold_q && con_q.io_en &&
					!rstreq_s) begin
					hold_d = 1'b0; // R14
				end
				if (con_q.io_en && cs_arm_q && cs_cnt_q == 5'h0 &&
					!(hold_q && state_q == scs_pkg::SCS_ACTIVATE)) begin
					con_d.clk_en = 1'b1; // R16
				end
				if (half_q >= scs_pkg::ACT_RST_HALF) begin
					state_d = scs_pkg::SCS_ACTIVE;
					half_d  = scs_pkg::ACT_RST_HALF;
				end
				if (state_q == scs_pkg::SCS_ACTIVE) begin
					con_d.rst_lvl = rstreq_s; // R15
				end
				if (req_n_s || fault_s || !present_q) begin
					state_d       = scs_pkg::SCS_DEACT; // R18
					con_d.rst_lvl = 1'b0;               // R18
					half_d        = 4'h0;
					fault_d       = fault_s || !present_q; // R20
				end
			end
			scs_pkg::SCS_DEACT: begin
				con_d.rst_lvl = 1'b0;
				cs_arm_d      = 1'b0;
				if (half_q >= scs_pkg::DEA_CLK_HALF) begin
					con_d.clk_en = 1'b0; // R18
				end
				if (half_q >= scs_pkg::DEA_IO_HALF) begin
					con_d.io_en = 1'b0; // R18
				end
				if (half_q >= scs_pkg::DEA_VCC_HALF) begin
					con_d.vcc_en = 1'b0; // R19
				end
				if (half_q >= scs_pkg::DEA_OFF_HALF) begin
					con_d.pump_en = 1'b0; // R19
					state_d       = scs_pkg::SCS_INACTIVE;
				end
			end
		endcase
	end

	// Clock request for the gate
	assign want_clk = con_q.clk_en;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= scs_pkg::SCS_INACTIVE; // R9
			con_q     <= '0;
			half_q    <= 4'h0;
			hold_q    <= 1'b0;
			fault_q   <= 1'b0;
			cs_cnt_q  <= 5'h0;
			cs_arm_q  <= 1'b0;
			osc_q     <= 1'b1; // Matches synchroniser reset: no false edge
			osc_cnt_q <= 6'h0;
			deb_q     <= 24'h0;
			present_q <= 1'b0;
			gate_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			con_q     <= con_d;
			half_q    <= half_d;
			hold_q    <= hold_d;
			fault_q   <= fault_d;
			cs_cnt_q  <= cs_cnt_d;
			cs_arm_q  <= cs_arm_d;
			osc_q     <= osc_s;
			osc_cnt_q <= osc_cnt_d;
			deb_q     <= deb_d;
			present_q <= present_d;
			gate_q    <= gate_d;
		end
	end

	// Status: presence when idle, low on any fault in a session
	logic status_q, status_d;
	always_comb begin
		status_d = status_q;
		if (state_q == scs_pkg::SCS_INACTIVE) begin
			status_d = present_q && !(fault_q && !req_n_s); // R10 R21
		end else if (fault_s || !present_q || fault_q) begin
			status_d = 1'b0; // R20 R22
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= 1'b0;
		end else begin
			status_q <= status_d;
		end
	end

	// Outputs from registers; card clock gated, oscillator select decoded from state
	assign status_n_o      = status_q;
	assign card_clock_o    = cclk_q & gate_q;
	assign card_reset_o    = con_q.rst_lvl;
	assign contact_o       = con_q;
	assign osc_high_freq_o = (state_q != scs_pkg::SCS_INACTIVE); // R11 R19

	// Three identical transceivers
	generate
		for (genvar i = 0; i < 3; i++) begin : g_line
			scs_line_xcvr u_xcvr (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.enable_i   (con_q.io_en),
				.host_in_i  (host_s[i]),
				.host_out_o (host_line_out_o[i]),
				.host_oe_o  (host_line_oe_o[i]),
				.card_in_i  (card_s[i]),
				.card_out_o (card_line_out_o[i]),
				.card_oe_o  (card_line_oe_o[i])
			);
		end
	endgenerate

endmodule // scs_sequencer

// ### tb/scs_sequencer_props.sv
// Checker for the contact sequencer: contact ordering, reset state, status.
// Bound onto scs_sequencer; sees its ports only.
module scs_sequencer_props (
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	// Watched pins
	input wire logic                  fault_i,
	input wire logic                  card_detect_input_i,
	input wire logic                  status_n_o,
	input wire logic                  card_reset_o,
	input wire scs_pkg::scs_contact_t contact_o,
	input wire logic [2:0]            card_line_oe_o,
	input wire logic [2:0]            card_line_out_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Contacts nest: pump, supply, lines, then clock and reset
	a_vcc_needs_pump: assert property (contact_o.vcc_en |-> contact_o.pump_en)
		else $error("supply on without pump");
	a_io_needs_vcc: assert property (contact_o.io_en |-> contact_o.vcc_en)
		else $error("lines on without supply");
	a_clk_needs_io: assert property (contact_o.clk_en |-> contact_o.io_en)
		else $error("clock on without lines");
	a_rst_needs_io: assert property (card_reset_o |-> contact_o.io_en)
		else $error("card reset high without lines");
	// Reset must be seen through, so this one ignores the default disable
	a_reset_inactive: assert property (disable iff (1'b0) rst_i |=>
		!status_n_o && contact_o == 5'h0)
		else $error("not inactive after reset");
	// Lines held low while not released, allowing two cycles of skew
	a_lines_held_low: assert property ((!contact_o.io_en)[*3] |->
		card_line_oe_o == 3'h7 && card_line_out_o == 3'h0)
		else $error("card lines not held low");
	a_fault_status: assert property ((fault_i && contact_o.vcc_en)[*5] |-> !status_n_o)
		else $error("status high during fault");
	a_absent_status: assert property ((!card_detect_input_i)[*6] |-> !status_n_o)
		else $error("status high without card");
endmodule // scs_sequencer_props

bind scs_sequencer scs_sequencer_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault_i),
	.card_detect_input_i(card_detect_input_i), .status_n_o(status_n_o),
	.card_reset_o(card_reset_o), .contact_o(contact_o),
	.card_line_oe_o(card_line_oe_o), .card_line_out_o(card_line_out_o)
);

// ### tb/scs_line_model.sv
// Far-side model of the three lines: host and card senders plus pull-ups.
// Assumes the bench asks for a low level through the pull inputs.
module scs_line_model (
	// Design drive
	input  wire logic [2:0] host_out_i,
	input  wire logic [2:0] host_oe_i,
	input  wire logic [2:0] card_out_i,
	input  wire logic [2:0] card_oe_i,
	// Far-side senders, open drain
	input  wire logic [2:0] host_pull_i,
	input  wire logic [2:0] card_pull_i,
	// Resolved wire levels
	output logic [2:0]      host_level_o,
	output logic [2:0]      card_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Senders only pull low; released wires float up to the pull-up
	assign host_level_o = ~((host_oe_i & ~host_out_i) | host_pull_i);
	assign card_level_o = ~((card_oe_i & ~card_out_i) | card_pull_i);
endmodule // scs_line_model

// ### tb/scs_sequencer_bench.sv
// Bench for the contact sequencer: sessions, divider, lines and faults.
// Assumes a 100 MHz clock and an internal oscillator of two clock periods.
module scs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HU = 64; // Half unit: 32 oscillator edges, 2 cycles each
	localparam int VCC = 4, PMP = 3, IO = 2, CKE = 0, ST = 5, RST = 6, OSC = 7, CC = 8;
	localparam int CLO = 9, CHI = 12, HLO = 15;
	logic clk_i = 0, rst_i = 1, osc = 0, sel_a = 0, sel_b = 0, req_n = 1, rreq = 0;
	logic det = 0, flt = 0, status_n, card_clk, card_rst, oschf;
	logic [2:0] hpull = 0, cpull = 0, hl_out, hl_oe, cl_out, cl_oe, hlev, clev;
	logic [17:0] mon;
	scs_pkg::scs_contact_t ct;
	int miscompares = 0, total_checks = 0, cyc = 0, n, a, b;
	int per [4] = '{4, 2, 2, 8}; // Registered output caps the undivided rate
	logic [1:0] codes [4] = '{2'h1, 2'h3, 2'h2, 2'h0}; // One bit per step

`define CHK(what, exp, got) begin total_checks++; \
	if ((got) !== (exp)) begin miscompares++; \
	$display("Error %s expected %0d seen %0d", what, exp, got); end end

	always #5 clk_i = ~clk_i;
	// Oscillator and cycle ceiling
	always @(posedge clk_i) begin
		#1 osc = ~osc;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	assign mon = {hl_oe & ~hl_out, cl_oe & cl_out, cl_oe & ~cl_out, card_clk, oschf,
		card_rst, status_n, ct};

	scs_sequencer #(.DEBOUNCE_CYC(16)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .osc_clock_input_i(osc),
		.clock_divide_select_a_i(sel_a), .clock_divide_select_b_i(sel_b),
		.session_request_n_i(req_n), .card_reset_request_i(rreq),
		.status_n_o(status_n), .card_detect_input_i(det), .fault_i(flt),
		.card_clock_o(card_clk), .card_reset_o(card_rst), .contact_o(ct),
		.osc_high_freq_o(oschf), .host_line_in_i(hlev), .host_line_out_o(hl_out),
		.host_line_oe_o(hl_oe), .card_line_in_i(clev), .card_line_out_o(cl_out),
		.card_line_oe_o(cl_oe));
	scs_line_model u_lines (
		.host_out_i(hl_out), .host_oe_i(hl_oe), .card_out_i(cl_out), .card_oe_i(cl_oe),
		.host_pull_i(hpull), .card_pull_i(cpull), .host_level_o(hlev),
		.card_level_o(clev));

	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	// Cycles until a watched bit reaches a level, -1 past the limit
	task automatic wait_sig(input int k, input logic v, input int lim, output int w);
		w = 0;
		while (mon[k] !== v && w >= 0) begin
			tick(1);
			w++;
			if (w > lim) w = -1;
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		tick(5);
		rst_i = 0;
		`CHK("status", 1'b0, status_n)
		`CHK("contacts", 5'h0, ct)
		det = 1;
		tick(6);
		`CHK("early status", 1'b0, status_n)
		wait_sig(ST, 1, 40, n); `CHK("debounce", 1, n >= 0)
		$display("Test reset and insertion done");
		req_n = 0;
		wait_sig(OSC, 1, 8, n); `CHK("osc high", 1, n >= 0)
		wait_sig(VCC, 1, 1200, n);
		wait_sig(IO, 1, 400, n); `CHK("vcc to io", 5 * HU, n)
		wait_sig(CKE, 1, 40, n); `CHK("clock start", 1, n >= 20 && n <= 23)
		tick(400);
		rreq = 1;
		wait_sig(RST, 1, 6, n); `CHK("reset follows", 1, n >= 0)
		`CHK("clock kept", 1'b1, ct.clk_en)
		rreq = 0;
		for (int i = 0; i < 4; i++) begin
			{sel_a, sel_b} = codes[i];
			tick(40);
			wait_sig(CC, 0, 20, n);
			wait_sig(CC, 1, 20, n);
			wait_sig(CC, 0, 20, a);
			wait_sig(CC, 1, 20, b);
			`CHK("clock period", per[i], a + b)
		end
		for (int i = 0; i < 3; i++) begin
			hpull[i] = 1;
			wait_sig(CLO + i, 1, 10, n); `CHK("copy low", 1, n >= 0)
			hpull[i] = 0;
			wait_sig(CHI + i, 1, 10, n); `CHK("pull-up pulse", 1, n >= 0)
			wait_sig(CHI + i, 0, 12, n); `CHK("pulse end", 1, n >= 0)
		end
		cpull[0] = 1;
		wait_sig(HLO, 1, 10, n); `CHK("host copy low", 1, n >= 0)
		cpull[0] = 0;
		tick(14);
		`CHK("host released", 3'h0, hl_oe)
		req_n = 1;
		wait_sig(CKE, 0, 200, n);
		wait_sig(IO, 0, 200, n); `CHK("clock to io", HU, n)
		wait_sig(VCC, 0, 200, n); `CHK("io to vcc", HU, n)
		wait_sig(PMP, 0, 600, n); `CHK("vcc to pump", 7 * HU, n)
		tick(2);
		`CHK("osc low", 1'b0, oschf)
		$display("Test session one done");
		rreq = 1;
		tick(2);
		req_n = 0;
		wait_sig(IO, 1, 1500, n);
		tick(30);
		`CHK("clock held", 1'b0, ct.clk_en)
		`CHK("reset held", 1'b0, card_rst)
		rreq = 0;
		wait_sig(CKE, 1, 6, n); `CHK("clock on release", 1, n >= 0)
		det = 0;
		wait_sig(ST, 0, 6, n); `CHK("removal status", 1, n >= 0)
		wait_sig(PMP, 0, 1500, n); `CHK("removal stop", 1, n >= 0)
		req_n = 1;
		det = 1;
		wait_sig(ST, 1, 40, n); `CHK("reinsert", 1, n >= 0)
		flt = 1;
		tick(10);
		`CHK("idle fault", 1'b1, status_n)
		flt = 0;
		$display("Test session two done");
		tick(4);
		req_n = 0;
		wait_sig(VCC, 1, 1200, n);
		flt = 1;
		wait_sig(ST, 0, 6, n); `CHK("fault status", 1, n >= 0)
		wait_sig(PMP, 0, 1500, n); `CHK("emergency stop", 1, n >= 0)
		flt = 0;
		req_n = 1;
		wait_sig(ST, 1, 10, n); `CHK("status back", 1, n >= 0)
		$display("Test fault session done");
		wrap_up();
	end
endmodule // scs_sequencer_bench
